/* logic/asm_cmp.sv */
`timescale 1ns/100ps

module asm_cmp #(
  parameter int W = 16
) (
  // Quantity and its limits
  input  wire logic [W-1:0] val,
  input  wire logic [W-1:0] hi,
  input  wire logic [W-1:0] lo,
  // Limit violations
  output logic              over,
  output logic              under
);

  assign over  = val > hi;
  assign under = val < lo;

endmodule : asm_cmp

/* logic/asm_pick.sv */
`timescale 1ns/100ps

module asm_pick
  import asm_pkg::*;
(
  // Visible alarms in, chosen alarm out
  asm_if.pick al
);

  // Strict compare keeps the lowest index among equal levels
  always_comb begin
    al.vld = 1'b0;
    al.idx = 4'h0;
    al.lvl = LVL_IGNORE;
    for (int i = 0; i < NALM; i++) begin
      if (al.vis[i] && (!al.vld || al.sev[2*i +: 2] > al.lvl)) begin
        al.vld = 1'b1;
        al.idx = 4'(i);
        al.lvl = al.sev[2*i +: 2];
      end
    end
  end

endmodule : asm_pick

/* logic/asm_top.sv */
// Operation
// - Level 0 alarm: no display, no output
// - Level 1 alarm: display only
// - Level 2 alarm: display and discrete output
// - Level 3 alarm: display, stop measurement, except weighing alarms alone under policy 1
// - Any level 3 alarm except weighing alarms alone under policy 1 (limit start): analog outputs minimum
// - Display shows highest severity alarm
// - Severities 0 to 3, listed faults reset 3
// - Reply supervision 0 off, 1 on, reset off
// - Missing reply input raises reply loss alarm
// - Load cell wiring fault raises alarm
// - Belt drift raises alarm, default level 2
// - Weighing signal above 30 mV raises alarm
// - Weighing signal below 0.05 mV raises alarm
// - Flow above/below setting raises alarms, level 2
// - Flow deviation beyond setting raises alarm
// - Control adjustment outside limits raises alarms
// - Belt speed outside limits raises alarms
// - Belt load outside limits raises alarms
// - Policy 1 keeps ready despite load cell errors
// - Error when several non-limit alarms active
`timescale 1ns/100ps

module asm_top
  import asm_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          NRST,
  // Register port
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [DW-1:0] RDATA,
  // Fault sources
  input  wire logic          MEM_FAULT,
  input  wire logic          RTC_FAULT,
  input  wire logic          REPLY_PRESENT,
  input  wire logic          WIRING_FAULT,
  input  wire logic          BELT_DRIFT,
  // Measured quantities
  input  wire logic [LW-1:0] WEIGH_SIG,
  input  wire logic [LW-1:0] FLOW,
  input  wire logic [LW-1:0] CTRL_ADJ,
  input  wire logic [LW-1:0] SPEED,
  input  wire logic [LW-1:0] LOAD,
  // Display indication
  output logic               DISP_VALID,
  output logic      [3:0]    DISP_ALARM,
  output logic      [1:0]    DISP_LEVEL,
  // Plant actions
  output logic [NALM-1:0]    ALARM_DO,
  output logic               RUN_STOP,
  output logic               AO_FORCE_MIN,
  output logic               AO_LIMIT_START,
  output logic               READY,
  output logic               ERROR_OUT
);

  // ************************************************************
  // Reset release
  // ************************************************************

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Only the second flop is read; the first may still be settling
  // when the external reset is released off the clock edge.
  // Assertion of reset stays asynchronous, so the outputs fall to
  // their safe values even while the clock is stopped.
  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // Declarations
  // ************************************************************

  asm_state_t             s_q;
  asm_state_t             s_d;
  asm_if                  al ();

  logic [NCMP-1:0][LW-1:0] meas;
  logic [NCMP-1:0]         ovr;
  logic [NCMP-1:0]         und;
  logic                    w_over;
  logic                    w_under;
  logic [LW-1:0]           fdiff;
  logic                    fdev_big;
  logic [NALM-1:0]         act;
  logic [NALM-1:0]         vis;
  logic [NALM-1:0]         lvl2;
  logic [NALM-1:0]         ser;
  logic [NALM-1:0]         ready_blk;
  logic [NALM-1:0]         err_set;
  logic                    policy;
  logic                    weigh_ser;
  logic                    other_ser;
  logic [AW-1:0]           lim_off;
  logic [3:0]              lim_sel;

  // ************************************************************
  // Limit comparators
  // ************************************************************

  assign meas = {LOAD, SPEED, CTRL_ADJ, FLOW};

  // Slots 2g and 2g+1 hold the upper and lower limit of each
  // quantity: flow, control adjustment, belt speed, belt load.
  // Compares are strict, so a value equal to a limit is in range.
  // Limits reset to the full range, keeping these alarms quiet
  // until software has set them.
  generate
    for (genvar g = 0; g < NCMP; g++) begin : g_cmp
      asm_cmp #(
        .W     (LW)
      ) u_cmp (
        .val   (meas[g]),
        .hi    (s_q.lim[2*g]),
        .lo    (s_q.lim[2*g+1]),
        .over  (ovr[g]),
        .under (und[g])
      );
    end
  endgenerate

  // Weighing signal window is fixed, not programmable
  asm_cmp #(
    .W     (LW)
  ) u_weigh (
    .val   (WEIGH_SIG),
    .hi    (WEIGH_HI_CNT),
    .lo    (WEIGH_LO_CNT),
    .over  (w_over),
    .under (w_under)
  );

  // Deviation of flow from target, either direction.
  // Unsigned subtraction in the larger-first order cannot wrap.
  always_comb begin
    if (FLOW >= s_q.lim[LIM_FTGT]) begin
      fdiff = FLOW - s_q.lim[LIM_FTGT];
    end else begin
      fdiff = s_q.lim[LIM_FTGT] - FLOW;
    end
  end

  assign fdev_big = fdiff > s_q.lim[LIM_FDEV];

  // ************************************************************
  // Alarm conditions
  // ************************************************************

  always_comb begin
    act            = '0;
    act[IDX_MEM]   = MEM_FAULT;
    act[IDX_RTC]   = RTC_FAULT;
    // Supervision checks every cycle once enabled
    act[IDX_REPLY] = s_q.ctl[CTL_REPLY_BIT]
                     & ~REPLY_PRESENT;
    act[IDX_WIRE]  = WIRING_FAULT;
    act[IDX_DRIFT] = BELT_DRIFT;
    act[IDX_WHI]   = w_over;
    act[IDX_WLO]   = w_under;
    act[IDX_FHI]   = ovr[0];
    act[IDX_FLO]   = und[0];
    act[IDX_FDEV]  = fdev_big;
    act[IDX_CHI]   = ovr[1];
    act[IDX_CLO]   = und[1];
    act[IDX_SHI]   = ovr[2];
    act[IDX_SLO]   = und[2];
    act[IDX_LHI]   = ovr[3];
    act[IDX_LLO]   = und[3];
  end

  // ************************************************************
  // Severity grading
  // ************************************************************

  always_comb begin
    for (int i = 0; i < NALM; i++) begin
      vis[i]  = act[i]
                && s_q.sev[2*i +: 2] != LVL_IGNORE;
      lvl2[i] = act[i]
                && s_q.sev[2*i +: 2] == LVL_COMMON;
      ser[i]  = act[i]
                && s_q.sev[2*i +: 2] == LVL_SERIOUS;
    end
  end

  // For run and analog outputs the policy bit only matters while a weighing alarm is
  // serious; any other serious alarm still stops the run.
  assign policy    = s_q.ctl[CTL_POLICY_BIT];
  assign weigh_ser = |(ser & WEIGH_MASK);
  assign other_ser = |(ser & ~WEIGH_MASK);

  // Load cell alarms stop blocking ready under the limit policy
  assign ready_blk = policy ? (ser & ~CELL_MASK) : ser;

  // Limit alarms never count toward the combined error
  assign err_set = vis & ~LIMIT_MASK;

  // ************************************************************
  // Display priority
  // ************************************************************

  // Only visible alarms compete; level 0 never reaches the picker.
  // Ties go to the lowest index, so the order of the alarm
  // indices is also the display order within one level.
  assign al.vis = vis;
  assign al.sev = s_q.sev;

  asm_pick u_pick (
    .al (al.pick)
  );

  // ************************************************************
  // Next state
  // ************************************************************

  // Limit slot from the byte address; the range and alignment
  // tests below keep the slot inside the table.
  assign lim_off = ADDR - ADR_LIM0;
  assign lim_sel = lim_off[5:2];

  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;

    // Register writes
    if (WR) begin
      if (ADDR == ADR_SEV) begin
        s_d.sev = WDATA;
      end else if (ADDR == ADR_CTL) begin
        s_d.ctl = WDATA[1:0];
      end else if (ADDR >= ADR_LIM0 && ADDR < ADR_ACT
                   && ADDR[1:0] == 2'h0) begin
        s_d.lim[lim_sel] = WDATA[LW-1:0];
      end
    end

    // Writes to read-only or unmapped places are dropped
    // silently; the bus has no error response.

    // Register reads, data valid the following cycle only.
    // Read data returns to zero otherwise, so a stale value
    // can never be mistaken for a fresh answer.
    if (RD) begin
      if (ADDR == ADR_SEV) begin
        s_d.rdata = s_q.sev;
      end else if (ADDR == ADR_CTL) begin
        s_d.rdata = {30'h0, s_q.ctl};
      end else if (ADDR >= ADR_LIM0 && ADDR < ADR_ACT
                   && ADDR[1:0] == 2'h0) begin
        s_d.rdata = {16'h0, s_q.lim[lim_sel]};
      end else if (ADDR == ADR_ACT) begin
        s_d.rdata = {16'h0, s_q.act};
      end else if (ADDR == ADR_DISP) begin
        s_d.rdata = {23'h0, s_q.disp_vld,
                     2'h0, s_q.disp_lvl, s_q.disp_idx};
      end
    end

    // Alarm actions are registered so they move on edges
    s_d.act      = act;
    s_d.disp_vld = al.vld;
    s_d.disp_idx = al.idx;
    s_d.disp_lvl = al.lvl;
    s_d.dout     = lvl2;

    // A serious weighing alarm alone follows the policy bit
    s_d.stop     = other_ser
                   | (weigh_ser & ~policy);
    s_d.ao_min   = other_ser
                   | (weigh_ser & ~policy);
    s_d.ao_start = weigh_ser & policy
                   & ~other_ser;
    s_d.ready    = ~|ready_blk;
    // More than one bit set: clearing the lowest set bit
    // leaves something only when a second bit was set
    s_d.err      = |(err_set & (err_set - 16'h1));
  end

  // ************************************************************
  // State register
  // ************************************************************

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.sev      <= SEV_RST;
      s_q.ctl      <= CTL_RST;
      s_q.lim      <= LIM_RST;
      // Ready stays high in reset: no alarm is known yet
      s_q.ready    <= 1'b1;
    end else begin
      s_q          <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Every output comes straight from a flip-flop, so the plant
  // never sees a glitch from the alarm decoding above.

  assign RDATA          = s_q.rdata;
  assign DISP_VALID     = s_q.disp_vld;
  assign DISP_ALARM     = s_q.disp_idx;
  assign DISP_LEVEL     = s_q.disp_lvl;
  assign ALARM_DO       = s_q.dout;
  assign RUN_STOP       = s_q.stop;
  assign AO_FORCE_MIN   = s_q.ao_min;
  assign AO_LIMIT_START = s_q.ao_start;
  assign READY          = s_q.ready;
  assign ERROR_OUT      = s_q.err;

endmodule : asm_top

/* shared/asm_if.sv */
`timescale 1ns/100ps

interface asm_if;
  import asm_pkg::*;

  logic [NALM-1:0]   vis;
  logic [2*NALM-1:0] sev;
  logic              vld;
  logic [3:0]        idx;
  logic [1:0]        lvl;

  modport mgr  (output vis, sev, input  vld, idx, lvl);
  modport pick (input  vis, sev, output vld, idx, lvl);

endinterface : asm_if

/* shared/asm_pkg.sv */
package asm_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int NALM = 16;
  localparam int DW   = 32;
  localparam int AW   = 8;
  localparam int LW   = 16;
  localparam int NLIM = 10;
  localparam int NCMP = 4;

  // ************************************************************
  // Alarm indices, also bit positions in status words
  // ************************************************************
  localparam int IDX_MEM   = 0;
  localparam int IDX_RTC   = 1;
  localparam int IDX_REPLY = 2;
  localparam int IDX_WIRE  = 3;
  localparam int IDX_DRIFT = 4;
  localparam int IDX_WHI   = 5;
  localparam int IDX_WLO   = 6;
  localparam int IDX_FHI   = 7;
  localparam int IDX_FLO   = 8;
  localparam int IDX_FDEV  = 9;
  localparam int IDX_CHI   = 10;
  localparam int IDX_CLO   = 11;
  localparam int IDX_SHI   = 12;
  localparam int IDX_SLO   = 13;
  localparam int IDX_LHI   = 14;
  localparam int IDX_LLO   = 15;

  // Upper/lower limit alarms, kept out of the combined error
  localparam logic [NALM-1:0] LIMIT_MASK = 16'hfd80;
  // Load cell alarms, ignored for ready under the limit policy
  localparam logic [NALM-1:0] CELL_MASK  = 16'h0068;
  // Weighing over/under alarms
  localparam logic [NALM-1:0] WEIGH_MASK = 16'h0060;

  // ************************************************************
  // Severity levels
  // ************************************************************
  localparam logic [1:0] LVL_IGNORE  = 2'h0;
  localparam logic [1:0] LVL_SHOW    = 2'h1;
  localparam logic [1:0] LVL_COMMON  = 2'h2;
  localparam logic [1:0] LVL_SERIOUS = 2'h3;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [AW-1:0] ADR_SEV  = 8'h00;
  localparam logic [AW-1:0] ADR_CTL  = 8'h04;
  localparam logic [AW-1:0] ADR_LIM0 = 8'h08;
  localparam logic [AW-1:0] ADR_ACT  = 8'h30;
  localparam logic [AW-1:0] ADR_DISP = 8'h34;

  localparam int CTL_REPLY_BIT  = 0;
  localparam int CTL_POLICY_BIT = 1;
  localparam int DISP_LVL_POS   = 4;
  localparam int DISP_VLD_POS   = 8;

  // Limit slots: pairs hi/lo for flow, control, speed, load
  localparam int LIM_FTGT = 8;
  localparam int LIM_FDEV = 9;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2*NALM-1:0] SEV_RST = 32'haaaabeff;
  localparam logic [1:0]        CTL_RST = 2'h0;
  localparam logic [NLIM-1:0][LW-1:0] LIM_RST = {
    16'hffff, 16'h0000,
    16'h0000, 16'hffff, 16'h0000, 16'hffff,
    16'h0000, 16'hffff, 16'h0000, 16'hffff};

  // ************************************************************
  // Weighing signal thresholds, input LSB in microvolts
  // ************************************************************
  localparam int WEIGH_LSB_UV = 10;
  localparam int WEIGH_HI_UV  = 30000;
  localparam int WEIGH_LO_UV  = 50;
  localparam logic [LW-1:0] WEIGH_HI_CNT =
    LW'(WEIGH_HI_UV / WEIGH_LSB_UV);
  localparam logic [LW-1:0] WEIGH_LO_CNT =
    LW'(WEIGH_LO_UV / WEIGH_LSB_UV);

  // ************************************************************
  // State of the manager
  // ************************************************************
  typedef struct packed {
    logic [2*NALM-1:0]       sev;
    logic [1:0]              ctl;
    logic [NLIM-1:0][LW-1:0] lim;
    logic [DW-1:0]           rdata;
    logic [NALM-1:0]         act;
    logic                    disp_vld;
    logic [3:0]              disp_idx;
    logic [1:0]              disp_lvl;
    logic [NALM-1:0]         dout;
    logic                    stop;
    logic                    ao_min;
    logic                    ao_start;
    logic                    ready;
    logic                    err;
  } asm_state_t;

endpackage : asm_pkg

/* testbench/alarm_severity_manager_tb.sv */
`timescale 1ns/100ps

module alarm_severity_manager_tb
  import asm_pkg::*;
;
  typedef struct packed {
    logic [NALM-1:0] act;
    logic [NALM-1:0] dout;
    logic            vld;
    logic [3:0]      idx;
    logic [1:0]      lvl;
    logic            stop;
    logic            start;
    logic            rdy;
    logic            err;
  } asm_exp_t;

  logic                    CLK = 1'b0;
  logic                    NRST = 1'b0;
  logic [AW-1:0]           ADDR = '0;
  logic [DW-1:0]           WDATA = '0;
  logic                    WR = 1'b0;
  logic                    RD = 1'b0;
  logic [DW-1:0]           RDATA;
  logic [4:0]              flt_s = '0;
  logic [4:0][LW-1:0]      qty_s = '0;
  logic [4:0]              pins;
  logic [4:0][LW-1:0]      meas;
  logic [NALM-1:0]         dout;
  logic [3:0]              didx;
  logic [1:0]              dlvl;
  logic [5:0]              fl;
  logic [2*NALM-1:0]       sev_s;
  logic [1:0]              ctl_s = '0;
  logic [NLIM-1:0][LW-1:0] lim_s = LIM_RST;
  int                      failures = 0;
  int                      num_checks = 0;

  always #5 CLK = ~CLK;

  asm_plant_model plant (.flt(flt_s), .qty(qty_s), .pins(pins), .meas(meas));

  asm_top uut (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .MEM_FAULT(pins[0]), .RTC_FAULT(pins[1]),
    .REPLY_PRESENT(pins[2]), .WIRING_FAULT(pins[3]),
    .BELT_DRIFT(pins[4]), .WEIGH_SIG(meas[0]), .FLOW(meas[1]),
    .CTRL_ADJ(meas[2]), .SPEED(meas[3]), .LOAD(meas[4]),
    .DISP_VALID(fl[0]), .DISP_ALARM(didx), .DISP_LEVEL(dlvl),
    .ALARM_DO(dout), .RUN_STOP(fl[1]), .AO_FORCE_MIN(fl[2]),
    .AO_LIMIT_START(fl[3]), .READY(fl[4]), .ERROR_OUT(fl[5]));

  // ************
  // Checking
  // ************
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic asm_exp_t calc();
    asm_exp_t        e;
    logic [NALM-1:0] ser;
    logic [LW-1:0]   d;
    logic [1:0]      v;
    int              n;
    e = '0;
    ser = '0;
    n = 0;
    d = (qty_s[1] > lim_s[8]) ? qty_s[1] - lim_s[8] : lim_s[8] - qty_s[1];
    e.act = {qty_s[4] < lim_s[7], qty_s[4] > lim_s[6],
             qty_s[3] < lim_s[5], qty_s[3] > lim_s[4],
             qty_s[2] < lim_s[3], qty_s[2] > lim_s[2], d > lim_s[9],
             qty_s[1] < lim_s[1], qty_s[1] > lim_s[0],
             qty_s[0] < 16'h0005, qty_s[0] > 16'h0bb8,
             flt_s[4:3], ctl_s[0] & flt_s[2], flt_s[1:0]};
    for (int i = 0; i < NALM; i++) begin
      v = sev_s[2*i+:2];
      if (e.act[i] && v != 2'h0) begin
        if (!e.vld || v > e.lvl) begin
          e.vld = 1'b1;
          e.idx = 4'(i);
          e.lvl = v;
        end
        n += int'(!LIMIT_MASK[i]);
      end
      e.dout[i] = e.act[i] && v == 2'h2;
      ser[i] = e.act[i] && v == 2'h3;
    end
    e.stop = |(ser & ~WEIGH_MASK) || (|(ser & WEIGH_MASK) && !ctl_s[1]);
    e.start = |(ser & WEIGH_MASK) && ctl_s[1] && !(|(ser & ~WEIGH_MASK));
    e.rdy = !(|(ser & (ctl_s[1] ? ~CELL_MASK : '1)));
    e.err = n > 1;
    return e;
  endfunction : calc

  // ************
  // Bus and scene drivers
  // ************
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    if (a == ADR_SEV)
      sev_s = d;
    if (a == ADR_CTL)
      ctl_s = d[1:0];
    if (a >= ADR_LIM0 && a < ADR_ACT && a[1:0] == 2'h0)
      lim_s[(a - ADR_LIM0) >> 2] = d[LW-1:0];
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd

  task automatic apply(input logic [4:0] f, input logic [4:0][LW-1:0] q);
    asm_exp_t e;
    @(posedge CLK);
    flt_s <= f;
    qty_s <= q;
    @(posedge CLK);
    #1 e = calc();
    chk(DW'(dout), DW'(e.dout));
    chk(DW'(fl[0]), DW'(e.vld));
    chk(DW'({dlvl, didx}), DW'({e.lvl, e.idx}));
    chk(DW'(fl[2:1]), DW'({2{e.stop}}));
    chk(DW'(fl[3]), DW'(e.start));
    chk(DW'(fl[4]), DW'(e.rdy));
    chk(DW'(fl[5]), DW'(e.err));
  endtask : apply

  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    logic [DW-1:0]      r;
    logic [4:0][LW-1:0] q;
    logic [AW-1:0]      a;
    asm_exp_t           e;
    for (int i = 0; i < NALM; i++)
      sev_s[2*i+:2] = (i < 4 || i == 5 || i == 6) ? 2'h3 : 2'h2;
    void'($urandom(52));
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(ADR_SEV, r);
    chk(r, sev_s);
    rd(ADR_CTL, r);
    chk(r, '0);
    // Every level against both policies, weighing thresholds at the edge
    for (int lv = 0; lv < 4; lv++) begin
      for (int p = 0; p < 2; p++) begin
        wr(ADR_SEV, {NALM{2'(lv)}});
        wr(ADR_CTL, DW'(2 * p + 1));
        for (int k = 0; k < 6; k++) begin
          q = '0;
          q[0] = (k < 2) ? 16'h0bb8 + LW'(k) :
                 (k < 4) ? 16'h0005 - LW'(k - 2) : 16'h0064;
          apply((k == 4) ? 5'h01 : (k == 5) ? 5'h1f : 5'h00, q);
        end
      end
    end
    // Unmapped and misaligned places are refused
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, r);
    chk(r, '0);
    wr(ADR_SEV + 8'h01, '0);
    rd(ADR_SEV, r);
    chk(r, sev_s);
    for (int n = 0; n < 400; n++) begin
      if ($urandom % 4 == 0) begin
        case ($urandom % 4)
          0: a = ADR_SEV;
          1: a = ADR_CTL;
          2: a = ADR_LIM0 + AW'(4 * ($urandom % NLIM));
          default: a = ADR_ACT + AW'(4 * ($urandom % 4));
        endcase
        wr(a, $urandom);
      end
      for (int j = 1; j < 5; j++)
        q[j] = LW'($urandom);
      q[0] = LW'($urandom % ((n % 3 == 0) ? 8 : 3004));
      apply(5'($urandom) & 5'($urandom), q);
      if (n % 16 == 0) begin
        e = calc();
        rd(ADR_ACT, r);
        chk(r, DW'(e.act));
        rd(ADR_DISP, r);
        chk(r, {23'h0, e.vld, 2'h0, e.lvl, e.idx});
      end
    end
    summarize();
  end
endmodule : alarm_severity_manager_tb

/* testbench/asm_monitor.sv */
`timescale 1ns/100ps

module asm_monitor
  import asm_pkg::*;
(
  // Clock, reset, read port
  input wire logic            CLK,
  input wire logic            NRST,
  input wire logic            RD,
  input wire logic [DW-1:0]   RDATA,
  // Causes
  input wire logic            MEM_FAULT,
  input wire logic            REPLY_PRESENT,
  input wire logic            WIRING_FAULT,
  input wire logic            BELT_DRIFT,
  input wire logic [LW-1:0]   WEIGH_SIG,
  // Effects
  input wire logic            DISP_VALID,
  input wire logic [1:0]      DISP_LEVEL,
  input wire logic [NALM-1:0] ALARM_DO,
  input wire logic            RUN_STOP,
  input wire logic            AO_FORCE_MIN,
  input wire logic            AO_LIMIT_START,
  input wire logic            READY,
  input wire logic            ERROR_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_zero_hidden: assert property (DISP_VALID |-> DISP_LEVEL != 2'h0)
    else $error("level zero shown");
  a_do_shown: assert property (|ALARM_DO |-> DISP_VALID && DISP_LEVEL >= 2'h2)
    else $error("output without display");
  a_stop_shown: assert property (RUN_STOP |-> DISP_VALID && DISP_LEVEL == 2'h3)
    else $error("stop without serious");
  a_stop_min: assert property (RUN_STOP == AO_FORCE_MIN)
    else $error("stop and minimum differ");
  a_ready_low: assert property (!READY |-> DISP_VALID && DISP_LEVEL == 2'h3)
    else $error("ready low without serious");
  a_start_only: assert property (AO_LIMIT_START |-> !RUN_STOP && DISP_LEVEL == 2'h3)
    else $error("limit with stop");
  a_do_reply: assert property (ALARM_DO[IDX_REPLY] |-> !$past(REPLY_PRESENT))
    else $error("reply alarm with reply");
  a_do_wire: assert property (ALARM_DO[IDX_WIRE] |-> $past(WIRING_FAULT))
    else $error("wiring alarm without fault");
  a_do_drift: assert property (ALARM_DO[IDX_DRIFT] |-> $past(BELT_DRIFT))
    else $error("drift alarm without drift");
  a_weigh_high: assert property (ALARM_DO[IDX_WHI] |-> $past(WEIGH_SIG) > 16'h0bb8)
    else $error("weigh high too early");
  a_weigh_low: assert property (ALARM_DO[IDX_WLO] |-> $past(WEIGH_SIG) < 16'h0005)
    else $error("weigh low too early");
  a_do_mem: assert property (ALARM_DO[IDX_MEM] |-> $past(MEM_FAULT))
    else $error("memory alarm without fault");
  a_err_shown: assert property (ERROR_OUT |-> DISP_VALID)
    else $error("error without display");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
    else $error("read data outside slot");
  a_rst_quiet: assert property (disable iff (1'b0) (!NRST) [*3] |-> READY && !RUN_STOP && ALARM_DO == '0)
    else $error("outputs active in reset");

  c_stop: cover property (RUN_STOP);
  c_start: cover property (AO_LIMIT_START);
  c_err: cover property (ERROR_OUT);
endmodule : asm_monitor

bind asm_top asm_monitor u_mon (
  .CLK(CLK), .NRST(NRST), .RD(RD), .RDATA(RDATA),
  .MEM_FAULT(MEM_FAULT), .REPLY_PRESENT(REPLY_PRESENT),
  .WIRING_FAULT(WIRING_FAULT), .BELT_DRIFT(BELT_DRIFT),
  .WEIGH_SIG(WEIGH_SIG), .DISP_VALID(DISP_VALID),
  .DISP_LEVEL(DISP_LEVEL), .ALARM_DO(ALARM_DO), .RUN_STOP(RUN_STOP),
  .AO_FORCE_MIN(AO_FORCE_MIN), .AO_LIMIT_START(AO_LIMIT_START),
  .READY(READY), .ERROR_OUT(ERROR_OUT));

/* testbench/asm_plant_model.sv */
`timescale 1ns/100ps

module asm_plant_model
  import asm_pkg::*;
(
  // Scene requested by the bench
  input  wire logic [4:0]         flt,
  input  wire logic [4:0][LW-1:0] qty,
  // Lines toward the manager
  output logic      [4:0]         pins,
  output logic      [4:0][LW-1:0] meas
);
  // A lost reply shows as a low presence level
  assign pins = flt ^ 5'h04;
  assign meas = qty;
endmodule : asm_plant_model
